// >>> hw/sbf_pkg.sv
// package: register map, field positions, reset values and timing counts
package sbf_pkg;
  localparam logic [3:0] STATUS_TWO_OFFSET = 4'h0; // serial_status_two
  localparam logic [3:0] CONTROL_OFFSET = 4'h4;    // control bits
  localparam int BREAK_FLAG_BIT = 7;
  localparam int EDGE_FLAG_BIT = 6;
  localparam int RX_INVERT_BIT = 4;
  localparam int LONG_BREAK_BIT = 1;
  localparam int RX_ACTIVE_BIT = 0;
  localparam int NINE_BIT_BIT = 2;
  localparam int BRK_BASE_BITS = 10;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] BIT_DIV_RESET = 16'h0015; // 40 MHz / 115200 / 16
  localparam logic [15:0] CONTROL_BIT_DIV_OFF = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int OVS = 16; // samples per bit time
  typedef enum logic [1:0] {S_IDLE, S_LOW, S_WAIT_HIGH} sbf_brk_state_t;
endpackage : sbf_pkg

// >>> hw/sbf_pin_sync.sv
// receive-pin synchroniser with three flip-flops and agreement filter
`timescale 1ns/1ps
module sbf_pin_sync (
  input wire logic aclk, // bus clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic pin_in, // raw asynchronous pin
  output logic level_out // filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  wire agree = (s2_reg == s3_reg);
  // idle line is high, so the reset values match an idle pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      level_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) level_reg <= s3_reg;
    end
  end
  assign level_out = level_reg;
endmodule : sbf_pin_sync

// >>> hw/sbf_status_two.sv
// second status register: break-detect and receive-edge flags, axi4-lite
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Function
// - break-detect flag bit 7 sets on detected break while detection enabled; sticky.
// - writing one to bit 7 clears break-detect flag; zero leaves it.
// - receive-edge flag bit 6 sets on falling edge, rising when inverted.
// - writing one to bit 6 clears receive-edge flag; zero no effect.
// - break length 10 bits (11 nine-bit), long mode 11 (12); suppress errors.
// - receive inversion applies before all edge and break logic.
module sbf_status_two
  import sbf_pkg::*;
(
  input wire logic aclk, // bus clock, 40 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic rx_pin, // receive pin, asynchronous
  input wire logic break_enable, // break detection circuitry enabled
  input wire logic [31:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [31:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic rx_data, // receive line after inversion
  output logic break_detected, // one-cycle pulse per break
  output logic suppress_errors // inhibit framing and full flags
);
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic aw_have_reg;
  logic w_have_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic w_lane0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] control_reg;
  logic [15:0] bit_div_reg;
  logic break_flag_reg;
  logic edge_flag_reg;
  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready = !w_have_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  wire aw_fire = awvalid && awready;
  wire w_fire = wvalid && wready;
  wire aw_ok = aw_have_reg || aw_fire;
  wire w_ok = w_have_reg || w_fire;
  wire [3:0] wr_addr = aw_have_reg ? aw_addr_reg : awaddr[3:0];
  wire [31:0] wr_data = w_have_reg ? w_data_reg : wdata;
  wire wr_lane0 = w_have_reg ? w_lane0_reg : wstrb[0];
  wire wr_lane1 = w_have_reg ? w_data_reg[31] : wstrb[1];
  wire wr_go = aw_ok && w_ok && !bvalid_reg;
  wire wr_status = wr_go && wr_addr == STATUS_TWO_OFFSET && wr_lane0;
  wire wr_control = wr_go && wr_addr == CONTROL_OFFSET;
  wire wr_mapped = (wr_addr == STATUS_TWO_OFFSET) ||
                   (wr_addr == CONTROL_OFFSET);
  wire clr_break = wr_status && wr_data[BREAK_FLAG_BIT];
  wire clr_edge = wr_status && wr_data[EDGE_FLAG_BIT];
  wire rd_go = arvalid && arready;
  wire long_break = control_reg[LONG_BREAK_BIT];
  wire rx_invert = control_reg[RX_INVERT_BIT];
  wire nine_bit = control_reg[NINE_BIT_BIT];
  logic rx_active_reg;
  wire [7:0] status_view = {break_flag_reg, edge_flag_reg, 1'b0,
                            rx_invert, 1'b0, 1'b0, long_break,
                            rx_active_reg};
  wire [31:0] rd_value = (araddr[3:0] == STATUS_TWO_OFFSET) ?
                         {24'h000000, status_view} :
                         {8'h00, bit_div_reg, control_reg};
  wire rd_mapped = (araddr[3:0] == STATUS_TWO_OFFSET) ||
                   (araddr[3:0] == CONTROL_OFFSET);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_have_reg <= 1'b1;
          aw_addr_reg <= awaddr[3:0];
        end
        if (w_fire) begin
          w_have_reg <= 1'b1;
          w_data_reg <= {wstrb[1], wdata[30:0]};
          w_lane0_reg <= wstrb[0];
        end
      end
      if (bvalid_reg && bready) bvalid_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mapped ? rd_value : 32'h00000000;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  // control: byte 0 holds mode bits, byte 1 the low byte of the sample divider; byte 2 reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_reg <= CONTROL_RESET;
      bit_div_reg <= BIT_DIV_RESET;
    end else if (wr_control) begin
      if (wr_lane0) control_reg <= wr_data[7:0];
      if (wr_lane1) bit_div_reg <= {8'h00, wr_data[15:8]};
    end
  end
  // ---------------------------------------------------------------
  // receive line and edge detect
  // ---------------------------------------------------------------
  logic pin_level;
  sbf_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(rx_pin),
    .level_out(pin_level)
  );
  wire line = pin_level ^ rx_invert;
  logic line_prev_reg;
  // after inversion the active edge is always high to low
  wire edge_event = line_prev_reg && !line;
  // ---------------------------------------------------------------
  // break detector: counts low samples in bit times
  // ---------------------------------------------------------------
  logic [15:0] div_cnt_reg;
  logic [3:0] smp_cnt_reg;
  logic [4:0] bits_low_reg;
  sbf_brk_state_t st_reg;
  wire tick = (div_cnt_reg == 16'h0000);
  wire bit_tick = tick && smp_cnt_reg == 4'(OVS - 1);
  wire [4:0] brk_len = 5'(BRK_BASE_BITS) + {4'h0, long_break} +
                       {4'h0, nine_bit};
  wire brk_event = bit_tick && st_reg == S_LOW &&
                   (bits_low_reg + 5'd1) == brk_len && break_enable;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= CONTROL_BIT_DIV_OFF;
      smp_cnt_reg <= 4'h0;
      bits_low_reg <= 5'd0;
      st_reg <= S_IDLE;
      line_prev_reg <= 1'b1;
      rx_active_reg <= 1'b0;
    end else begin
      line_prev_reg <= line;
      div_cnt_reg <= tick ? bit_div_reg : div_cnt_reg - 16'h0001;
      if (tick) smp_cnt_reg <= smp_cnt_reg + 4'h1;
      case (st_reg)
        S_IDLE: begin
          if (edge_event) begin
            st_reg <= S_LOW;
            smp_cnt_reg <= 4'h0;
            div_cnt_reg <= bit_div_reg;
            bits_low_reg <= 5'd0;
            rx_active_reg <= 1'b1;
          end
        end
        S_LOW: begin
          if (line) begin
            st_reg <= S_IDLE;
            rx_active_reg <= 1'b0;
          end else if (bit_tick) begin
            bits_low_reg <= bits_low_reg + 5'd1;
            if (brk_event) st_reg <= S_WAIT_HIGH;
          end
        end
        S_WAIT_HIGH: begin
          // one break per low stretch, however long it lasts
          if (line) begin
            st_reg <= S_IDLE;
            rx_active_reg <= 1'b0;
          end
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // sticky flags
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      break_flag_reg <= STATUS_RESET[BREAK_FLAG_BIT];
      edge_flag_reg <= STATUS_RESET[EDGE_FLAG_BIT];
    end else begin
      if (brk_event) break_flag_reg <= 1'b1;
      else if (clr_break) break_flag_reg <= 1'b0;
      if (edge_event) edge_flag_reg <= 1'b1;
      else if (clr_edge) edge_flag_reg <= 1'b0;
    end
  end
  assign rx_data = line;
  assign break_detected = brk_event;
  assign suppress_errors = long_break;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_edge_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_event |=> edge_flag_reg) else $error("edge flag not set");
  a_break_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    brk_event |=> break_flag_reg) else $error("break flag not set");
  a_break_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(break_flag_reg) |-> $past(break_enable))
    else $error("break flag without enable");
  a_break_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_break && !brk_event |=> !break_flag_reg)
    else $error("break flag not cleared");
  a_edge_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_edge && !edge_event |=> !edge_flag_reg)
    else $error("edge flag not cleared");
  a_edge_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    edge_flag_reg && !clr_edge |=> edge_flag_reg)
    else $error("edge flag dropped");
  a_break_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    break_flag_reg && !clr_break |=> break_flag_reg)
    else $error("break flag dropped");
  a_flags_reset: assert property (@(posedge aclk)
    !aresetn |=> !break_flag_reg && !edge_flag_reg)
    else $error("flags not reset");
  a_invert_line: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_data == (pin_level ^ control_reg[RX_INVERT_BIT]))
    else $error("line inversion wrong");
  a_break_length: assert property (@(posedge aclk) disable iff (!aresetn)
    brk_event |-> bits_low_reg == brk_len - 5'd1 && brk_len >= 5'd10)
    else $error("break length wrong");
endmodule : sbf_status_two

// >>> verification/sbf_remote_node.sv
// partner model: remote node that pulls the receive line away from idle
`timescale 1ns/1ps
module sbf_remote_node (
  input wire logic aclk, // bus clock
  input wire logic idle_level, // line level between frames
  input wire logic start, // begin one active stretch
  input wire logic [15:0] low_len, // stretch length in cycles
  output logic rx_pin, // line seen by the receiver
  output logic busy // stretch in progress
);
  logic [15:0] cnt_reg = 16'h0000;
  always_ff @(posedge aclk) begin
    if (start)
      cnt_reg <= low_len;
    else if (cnt_reg != 16'h0000)
      cnt_reg <= cnt_reg - 16'h0001;
  end
  assign busy = (cnt_reg != 16'h0000);
  // line sits at its idle level outside a stretch
  assign rx_pin = busy ? ~idle_level : idle_level;
endmodule : sbf_remote_node

// >>> verification/sbf_status_two_test.sv
// testbench: register access, edge flag and break flag scenarios
`timescale 1ns/1ps
module sbf_status_two_test;
  import sbf_pkg::*;
  localparam logic [31:0] ST = {28'h0, STATUS_TWO_OFFSET};
  localparam logic [31:0] CT = {28'h0, CONTROL_OFFSET};
  logic aclk = 1'b0, aresetn = 1'b0, break_enable = 1'b0;
  logic idle_level = 1'b1, start = 1'b0;
  logic [15:0] low_len = 16'h0000;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [31:0] brk_pulses = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_pin, busy;
  logic rx_data, break_detected, suppress_errors;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int num_errors = 0, cmp_count = 0;
  always #12.5 aclk = ~aclk;
  always @(negedge aclk) if (break_detected === 1'b1) brk_pulses++;
  sbf_remote_node i_node (.aclk(aclk), .idle_level(idle_level),
    .start(start), .low_len(low_len), .rx_pin(rx_pin), .busy(busy));
  sbf_status_two i_dut (.aclk(aclk), .aresetn(aresetn), .rx_pin(rx_pin),
    .break_enable(break_enable), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .rx_data(rx_data),
    .break_detected(break_detected), .suppress_errors(suppress_errors));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", what, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      $display("unexpected wait: expected under %0d, seen %0d", lim, n);
      num_errors++;
      wrap_up();
    end
  endtask : guard
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] rsp;
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    b_hs = 1'b0;
    while (!b_hs && n < 50) begin
      @(negedge aclk);
      aw_hs = awvalid && (awready === 1'b1);
      w_hs = wvalid && (wready === 1'b1);
      b_hs = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      n++;
    end
    if (!b_hs) guard(n, 50);
    bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, rsp});
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [1:0] er,
                    output logic [31:0] d);
    logic ar_hs, r_hs;
    logic [1:0] rsp;
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    r_hs = 1'b0;
    while (!r_hs && n < 50) begin
      @(negedge aclk);
      ar_hs = arvalid && (arready === 1'b1);
      r_hs = (rvalid === 1'b1);
      d = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
      n++;
    end
    if (!r_hs) guard(n, 50);
    rready <= 1'b0;
    chk("read response", {30'h0, er}, {30'h0, rsp});
  endtask : rd
  task automatic st(input logic [31:0] mask, input logic [31:0] e);
    logic [31:0] d;
    rd(ST, RESP_OKAY, d);
    chk("status flags", e, d & mask);
  endtask : st
  task automatic pulse(input int len);
    @(posedge aclk);
    start <= 1'b1;
    low_len <= 16'(len);
    @(posedge aclk);
    start <= 1'b0;
  endtask : pulse
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (busy !== 1'b0 && n < 1000);
    if (busy !== 1'b0) guard(n, 1000);
    repeat (10) @(posedge aclk);
  endtask : wait_idle
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset();
    logic [31:0] d;
    rd(ST, RESP_OKAY, d);
    chk("status reset", {24'h0, STATUS_RESET}, d);
    rd(CT, RESP_OKAY, d);
    chk("control reset", {16'h0, BIT_DIV_RESET[7:0], CONTROL_RESET}, d);
    rd(32'h8, RESP_SLVERR, d);
    chk("unmapped read", 32'h0, d);
    wr(32'h8, 32'hff, RESP_SLVERR);
    st(32'hc0, 32'h0);
    $display("test reset done, mismatches %0d", num_errors);
  endtask : test_reset
  task automatic test_edge(input logic inv);
    // an inverted line idles low at the pin
    idle_level <= ~inv;
    wr(CT, {27'h0, inv, 4'h0}, RESP_OKAY);
    repeat (10) @(posedge aclk);
    wr(ST, 32'h40, RESP_OKAY);
    st(32'hc0, 32'h0);
    chk("line after inversion", 32'h1, {31'h0, rx_data});
    pulse(60);
    repeat (12) @(posedge aclk);
    st(32'hd1, {27'h0, inv, 4'h1} | 32'h40);
    wr(ST, 32'h0, RESP_OKAY);
    st(32'hc0, 32'h40);
    wr(ST, 32'h40, RESP_OKAY);
    wait_idle();
    st(32'hc0, 32'h0);
    wr(CT, 32'h0, RESP_OKAY);
    idle_level <= 1'b1;
    $display("test edge %0d done, mismatches %0d", inv, num_errors);
  endtask : test_edge
  task automatic test_break();
    logic [31:0] ctl [4] = '{32'h0, 32'h2, 32'h4, 32'h6};
    int bits [4] = '{10, 11, 11, 12};
    logic [31:0] p0;
    break_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(CT, ctl[i], RESP_OKAY);
      chk("suppress", {31'h0, ctl[i][1]}, {31'h0, suppress_errors});
      st(32'h12, ctl[i] & 32'h2);
      wr(ST, 32'hc0, RESP_OKAY);
      pulse(bits[i] * 16 - 8);
      wait_idle();
      st(32'h80, 32'h0);
      p0 = brk_pulses;
      pulse(bits[i] * 16 + 8);
      wait_idle();
      st(32'h80, 32'h80);
      chk("break pulses", 32'h1, brk_pulses - p0);
    end
    wr(ST, 32'h0, RESP_OKAY);
    st(32'hc0, 32'hc0);
    wr(ST, 32'h80, RESP_OKAY);
    st(32'hc0, 32'h40);
    break_enable <= 1'b0;
    wr(ST, 32'hc0, RESP_OKAY);
    pulse(220);
    wait_idle();
    st(32'h80, 32'h0);
    $display("test break done, mismatches %0d", num_errors);
  endtask : test_break
  task automatic test_midreset();
    pulse(20);
    wait_idle();
    st(32'hc0, 32'h40);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st(32'hc0, 32'h0);
    $display("test midreset done, mismatches %0d", num_errors);
  endtask : test_midreset
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_edge(1'b0);
    test_edge(1'b1);
    test_break();
    test_midreset();
    wrap_up();
  end
endmodule : sbf_status_two_test
